/* File: iogx_pkg.sv */
`default_nettype none
package iogx_pkg;

  // ************************************************************
  // register map, byte addresses of the AHB-Lite slave
  // ************************************************************
  localparam logic [4:0] IOGX_OFS_INPUT = 5'h00;
  localparam logic [4:0] IOGX_OFS_OUTPUT = 5'h04;
  localparam logic [4:0] IOGX_OFS_POLARITY = 5'h08;
  localparam logic [4:0] IOGX_OFS_CONFIG = 5'h0c;
  localparam logic [4:0] IOGX_OFS_STATUS = 5'h10;
  localparam logic [4:0] IOGX_OFS_MASK = 5'h14;
  localparam logic [4:0] IOGX_OFS_ADDRESS = 5'h18;

  // command byte index of each port register over the serial link
  localparam logic [1:0] IOGX_CMD_INPUT = 2'h0;
  localparam logic [1:0] IOGX_CMD_OUTPUT = 2'h1;
  localparam logic [1:0] IOGX_CMD_POLARITY = 2'h2;
  localparam logic [1:0] IOGX_CMD_CONFIG = 2'h3;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0] IOGX_CFG_RST = 8'hff;
  localparam logic [7:0] IOGX_POL_RST = 8'h00;
  localparam logic [7:0] IOGX_OUT_RST = 8'hff;
  localparam logic [7:0] IOGX_INP_RST = 8'h00;
  localparam logic [2:0] IOGX_STS_RST = 3'h0;
  localparam logic [2:0] IOGX_MASK_RST = 3'h0;
  localparam int IOGX_EV_CHANGE = 0;
  localparam int IOGX_EV_WRITE = 1;
  localparam int IOGX_EV_READ = 2;

  // ************************************************************
  // timing: serial clock rates against the 125 MHz core clock
  // ************************************************************
  localparam int IOGX_CLK_KHZ = 125000;
  localparam int IOGX_SCL_STD_KHZ = 100;
  localparam int IOGX_SCL_FAST_KHZ = 400;
  localparam int IOGX_SCL_FMP_KHZ = 1000;
  localparam int IOGX_SCL_MIN_PERIOD_CYC = IOGX_CLK_KHZ / IOGX_SCL_FMP_KHZ;

  // port register set carried as one unit
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] pol;
    logic [7:0] outp;
    logic [7:0] inp;
  } iogx_regs_t;

  typedef enum logic [3:0] {
    IOGX_IDLE, IOGX_ADDR, IOGX_AACK, IOGX_CMD, IOGX_CACK,
    IOGX_WDAT, IOGX_WACK, IOGX_RDAT, IOGX_RACK
  } iogx_state_t;

endpackage
`default_nettype wire

/* File: iogx_sync3.sv */
`default_nettype none
// ************************************************************
// three-stage synchroniser with agreement filter
// ************************************************************
module iogx_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous in, filtered out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_q;

  // s1 feeds only s2; a bit moves once s2 and s3 agree
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
    end
  end

  // reset to each line's idle level, so no false edge follows reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

/* File: iogx_expander.sv */
// Functional notes
// - each pin is input or output by its own direction bit, master-written
// - input and output port registers hold one bit per pin, eight each
// - polarity bits invert the value returned when the input register is read
// - every register except the input register reads back its contents to the bus master; an input read returns the live pins
// - interrupt pin low while any input pin differs from its input register bit
// - reset loads register defaults and returns the control machine to idle
// - after reset all eight pins are inputs, none driving
// - target address is a fixed part plus three address pins, 64 addresses
// - serial link works at 100 kHz, 400 kHz and 1 MHz clocks
`default_nettype none
module iogx_expander #(
  parameter logic FIXED_ADDR = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial link, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // general purpose pins
  input wire logic [7:0] gpio_pin_i,
  output logic [7:0] gpio_pin_o,
  output logic [7:0] gpio_pin_oe,
  // address straps
  input wire logic [2:0] addr_select_pin_i,
  // interrupts
  output logic int_n_o,
  output logic int_n_oe,
  output logic irq
);

  // ************************************************************
  // input synchronisation
  // ************************************************************
  logic scl_s;
  logic sda_s;
  logic [7:0] pins;
  logic [2:0] strap;

  iogx_sync3 #(.WIDTH(13), .RST_VAL(13'h1800)) u_sync ( // link lines start idle high
    .clk(hclk),
    .rst_n(hresetn),
    .d({scl_i, sda_i, gpio_pin_i, addr_select_pin_i}),
    .q({scl_s, sda_s, pins, strap})
  );

  // ************************************************************
  // state
  // ************************************************************
  iogx_pkg::iogx_regs_t regs, next_regs;
  iogx_pkg::iogx_state_t state, next_state;
  logic scl_q, sda_q;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] tx, next_tx;
  logic [1:0] cmd, next_cmd;
  logic rw, next_rw;
  logic oe, next_oe;
  logic [2:0] idle_val, next_idle_val;
  logic [2:0] start_val, next_start_val;
  logic [2:0] low_val, next_low_val;
  logic low_taken, next_low_taken;
  logic [2:0] status, next_status;
  logic [2:0] mask, next_mask;
  logic ap_wr, ap_rd, next_ap_wr, next_ap_rd;
  logic [4:0] ap_addr, next_ap_addr;
  logic [31:0] next_hrdata;
  logic int_act, next_int_act;
  logic mismatch_q;

  logic scl_rise, scl_fall, start_det, stop_det;
  logic [6:0] dev_addr;
  logic mismatch;
  logic [2:0] ev;
  logic [7:0] rd_input;

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
  assign rd_input = pins ^ regs.pol;
  // only pins configured as inputs take part in the comparison
  assign mismatch = |((pins ^ regs.inp) & regs.cfg);

  // address code per strap: low, high, tied to data, tied to clock
  always_comb
  begin
    dev_addr[6] = FIXED_ADDR;
    for (int i = 0; i < 3; i++)
    begin
      if (!idle_val[i])
        dev_addr[2*i +: 2] = 2'h0;
      else if (!low_val[i])
        dev_addr[2*i +: 2] = 2'h3;
      else if (!start_val[i])
        dev_addr[2*i +: 2] = 2'h2;
      else
        dev_addr[2*i +: 2] = 2'h1;
    end
  end

  // ************************************************************
  // serial target machine and register updates
  // ************************************************************
  always_comb
  begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_tx = tx;
    next_cmd = cmd;
    next_rw = rw;
    next_oe = oe;
    next_regs = regs;
    next_idle_val = idle_val;
    next_start_val = start_val;
    next_low_val = low_val;
    next_low_taken = low_taken;
    ev = 3'h0;
    ev[iogx_pkg::IOGX_EV_CHANGE] = mismatch & ~mismatch_q;

    // bus writes first; a serial write in the same cycle overrides
    if (ap_wr)
    begin
      unique case (ap_addr)
        iogx_pkg::IOGX_OFS_OUTPUT: next_regs.outp = hwdata[7:0];
        iogx_pkg::IOGX_OFS_POLARITY: next_regs.pol = hwdata[7:0];
        iogx_pkg::IOGX_OFS_CONFIG: next_regs.cfg = hwdata[7:0];
        default: ;
      endcase
    end
    // reading the input port latches the pins, which clears the change
    if (next_ap_rd && next_ap_addr == iogx_pkg::IOGX_OFS_INPUT)
      next_regs.inp = pins;

    // strap sampling for the address code, idle/start/first low
    if (state == iogx_pkg::IOGX_IDLE && scl_s && sda_s)
      next_idle_val = strap;
    if (scl_fall && !low_taken)
    begin
      next_low_val = strap;
      next_low_taken = 1'b1;
    end

    if (start_det)
    begin
      next_state = iogx_pkg::IOGX_ADDR;
      next_bitcnt = 4'h0;
      next_oe = 1'b0;
      next_start_val = strap;
      next_low_taken = 1'b0;
    end
    else if (stop_det)
    begin
      next_state = iogx_pkg::IOGX_IDLE;
      next_oe = 1'b0;
    end
    else
    begin
      unique case (state)
        iogx_pkg::IOGX_IDLE: ;
        iogx_pkg::IOGX_ADDR, iogx_pkg::IOGX_CMD, iogx_pkg::IOGX_WDAT:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == 4'h8)
          begin
            next_oe = 1'b1;
            if (state == iogx_pkg::IOGX_ADDR)
            begin
              next_rw = shreg[0];
              if (shreg[7:1] == dev_addr)
                next_state = iogx_pkg::IOGX_AACK;
              else
              begin
                next_state = iogx_pkg::IOGX_IDLE;
                next_oe = 1'b0;
              end
            end
            else if (state == iogx_pkg::IOGX_CMD)
            begin
              next_cmd = shreg[1:0];
              next_state = iogx_pkg::IOGX_CACK;
            end
            else
            begin
              unique case (cmd)
                iogx_pkg::IOGX_CMD_OUTPUT: next_regs.outp = shreg;
                iogx_pkg::IOGX_CMD_POLARITY: next_regs.pol = shreg;
                iogx_pkg::IOGX_CMD_CONFIG: next_regs.cfg = shreg;
                default: ;
              endcase
              ev[iogx_pkg::IOGX_EV_WRITE] = 1'b1;
              next_state = iogx_pkg::IOGX_WACK;
            end
          end
        end
        iogx_pkg::IOGX_AACK, iogx_pkg::IOGX_CACK, iogx_pkg::IOGX_WACK, iogx_pkg::IOGX_RACK:
        begin
          if (state == iogx_pkg::IOGX_RACK && scl_rise && sda_s)
            next_state = iogx_pkg::IOGX_IDLE; // master nack ends the read
          else if (scl_fall)
          begin
            next_bitcnt = 4'h0;
            next_oe = 1'b0;
            if (state == iogx_pkg::IOGX_CACK || state == iogx_pkg::IOGX_WACK)
              next_state = iogx_pkg::IOGX_WDAT;
            else if (state == iogx_pkg::IOGX_AACK && !rw)
              next_state = iogx_pkg::IOGX_CMD;
            else
            begin
              // read out the selected register, repeated while acked
              unique case (cmd)
                iogx_pkg::IOGX_CMD_INPUT: next_tx = rd_input;
                iogx_pkg::IOGX_CMD_OUTPUT: next_tx = regs.outp;
                iogx_pkg::IOGX_CMD_POLARITY: next_tx = regs.pol;
                default: next_tx = regs.cfg;
              endcase
              if (cmd == iogx_pkg::IOGX_CMD_INPUT)
                next_regs.inp = pins;
              next_oe = ~next_tx[7];
              ev[iogx_pkg::IOGX_EV_READ] = 1'b1;
              next_state = iogx_pkg::IOGX_RDAT;
            end
          end
        end
        iogx_pkg::IOGX_RDAT:
        begin
          if (scl_fall)
          begin
            if (bitcnt == 4'h7)
            begin
              next_oe = 1'b0;
              next_state = iogx_pkg::IOGX_RACK;
            end
            else
            begin
              next_bitcnt = bitcnt + 4'h1;
              next_tx = {tx[6:0], 1'b0};
              next_oe = ~tx[6];
            end
          end
        end
        default: next_state = iogx_pkg::IOGX_IDLE;
      endcase
    end
  end

  // ************************************************************
  // bus slave and interrupt next values
  // ************************************************************
  always_comb
  begin
    next_ap_wr = hsel & htrans[1] & hready & hwrite;
    next_ap_rd = hsel & htrans[1] & hready & ~hwrite;
    next_ap_addr = haddr[4:0];
    next_hrdata = hrdata;
    if (next_ap_rd)
    begin
      next_hrdata = 32'h0000_0000;
      unique case (next_ap_addr)
        iogx_pkg::IOGX_OFS_INPUT: next_hrdata[7:0] = rd_input;
        iogx_pkg::IOGX_OFS_OUTPUT: next_hrdata[7:0] = regs.outp;
        iogx_pkg::IOGX_OFS_POLARITY: next_hrdata[7:0] = regs.pol;
        iogx_pkg::IOGX_OFS_CONFIG: next_hrdata[7:0] = regs.cfg;
        iogx_pkg::IOGX_OFS_STATUS: next_hrdata[2:0] = status;
        iogx_pkg::IOGX_OFS_MASK: next_hrdata[2:0] = mask;
        iogx_pkg::IOGX_OFS_ADDRESS: next_hrdata[6:0] = dev_addr;
        default: ;
      endcase
    end
    next_mask = mask;
    next_status = status;
    if (ap_wr && ap_addr == iogx_pkg::IOGX_OFS_MASK)
      next_mask = hwdata[2:0];
    if (ap_wr && ap_addr == iogx_pkg::IOGX_OFS_STATUS)
      next_status = status & ~hwdata[2:0];
    // a new event beats a clear landing in the same cycle
    next_status = next_status | ev;
    next_int_act = mismatch;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      regs <= {iogx_pkg::IOGX_CFG_RST, iogx_pkg::IOGX_POL_RST,
               iogx_pkg::IOGX_OUT_RST, iogx_pkg::IOGX_INP_RST};
      state <= iogx_pkg::IOGX_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      cmd <= 2'h0;
      rw <= 1'b0;
      oe <= 1'b0;
      idle_val <= 3'h0;
      start_val <= 3'h7; // straps count as tied high until a frame classifies them
      low_val <= 3'h7;
      low_taken <= 1'b1;
      status <= iogx_pkg::IOGX_STS_RST;
      mask <= iogx_pkg::IOGX_MASK_RST;
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_addr <= 5'h00;
      hrdata <= 32'h0000_0000;
      int_act <= 1'b0;
      mismatch_q <= 1'b0;
    end
    else
    begin
      regs <= next_regs;
      state <= next_state;
      scl_q <= scl_s;
      sda_q <= sda_s;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      tx <= next_tx;
      cmd <= next_cmd;
      rw <= next_rw;
      oe <= next_oe;
      idle_val <= next_idle_val;
      start_val <= next_start_val;
      low_val <= next_low_val;
      low_taken <= next_low_taken;
      status <= next_status;
      mask <= next_mask;
      ap_wr <= next_ap_wr;
      ap_rd <= next_ap_rd;
      ap_addr <= next_ap_addr;
      hrdata <= next_hrdata;
      int_act <= next_int_act;
      mismatch_q <= mismatch;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;
  assign sda_o = 1'b0;
  assign sda_oe = oe;
  assign gpio_pin_o = regs.outp;
  assign gpio_pin_oe = ~regs.cfg;
  assign int_n_o = 1'b0;
  assign int_n_oe = int_act;
  assign irq = |(status & mask);

  // ************************************************************
  // assertions
  // ************************************************************
  logic first_cyc;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      first_cyc <= 1'b1;
    else
      first_cyc <= 1'b0;
  end

  property p_dir_write;
    @(posedge hclk) disable iff (!hresetn)
    (ap_wr && ap_addr == iogx_pkg::IOGX_OFS_CONFIG && state == iogx_pkg::IOGX_IDLE)
      |=> gpio_pin_oe == ~$past(hwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not applied");

  property p_inp_latch;
    @(posedge hclk) disable iff (!hresetn)
    (ap_rd && ap_addr == iogx_pkg::IOGX_OFS_INPUT) |-> regs.inp == $past(pins);
  endproperty
  a_inp_latch: assert property (p_inp_latch) else $error("input register not latched");

  property p_pol_read;
    @(posedge hclk) disable iff (!hresetn)
    (ap_rd && ap_addr == iogx_pkg::IOGX_OFS_INPUT) |-> hrdata[7:0] == ($past(pins) ^ $past(regs.pol));
  endproperty
  a_pol_read: assert property (p_pol_read) else $error("input read not inverted");

  property p_cfg_read;
    @(posedge hclk) disable iff (!hresetn)
    (ap_rd && ap_addr == iogx_pkg::IOGX_OFS_CONFIG) |-> hrdata == {24'h000000, $past(regs.cfg)};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

  property p_int_set;
    @(posedge hclk) disable iff (!hresetn)
    mismatch |=> int_n_oe;
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt not driven");

  property p_reset_vals;
    @(posedge hclk) disable iff (!hresetn)
    first_cyc |-> (regs.pol == iogx_pkg::IOGX_POL_RST && regs.outp == iogx_pkg::IOGX_OUT_RST
                   && status == iogx_pkg::IOGX_STS_RST && state == iogx_pkg::IOGX_IDLE);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset defaults wrong");

  property p_reset_inputs;
    @(posedge hclk) disable iff (!hresetn)
    first_cyc |-> gpio_pin_oe == 8'h00;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pin driving after reset");

  property p_addr_ack;
    @(posedge hclk) disable iff (!hresetn)
    (state == iogx_pkg::IOGX_ADDR && next_state == iogx_pkg::IOGX_AACK) |-> shreg[7:1] == dev_addr;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("acked wrong address");

  property p_sda_scl_low;
    @(posedge hclk) disable iff (!hresetn)
    $rose(sda_oe) |-> !scl_s;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("data driven while clock high");

  property p_int_release;
    @(posedge hclk) disable iff (!hresetn)
    !mismatch ##1 !mismatch |-> !int_n_oe;
  endproperty
  a_int_release: assert property (p_int_release) else $error("interrupt not released");

  c_write: cover property (@(posedge hclk) disable iff (!hresetn) ev[iogx_pkg::IOGX_EV_WRITE]);
  c_read: cover property (@(posedge hclk) disable iff (!hresetn) ev[iogx_pkg::IOGX_EV_READ]);
  c_int: cover property (@(posedge hclk) disable iff (!hresetn) $rose(int_n_oe) ##[1:1000] $fell(int_n_oe));
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule
`default_nettype wire

/* File: iogx_i2c_master.sv */
`default_nettype none
// ************************************************************
// behavioural serial bus master, far side of the expander
// ************************************************************
module iogx_i2c_master (
  // serial link, clock idles high between frames
  output logic scl,
  output logic sda_low,
  // resolved data line level, pulled up
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  int half = 40;

  // released bus at time zero
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // sets half from the full period of the serial clock, in ns
  task automatic set_rate(input int period_ns);
    half = period_ns / 2;
  endtask

  // one bit: data moves mid-low, sampled just before the fall
  task automatic bit_io(input logic b, output logic r);
    #(half / 2) sda_low = ~b;
    #(half - half / 2) scl = 1'b1;
    #(half - 1) r = sda;
    #1 scl = 1'b0;
  endtask

  // start and stop conditions
  task automatic start_cond();
    #half sda_low = 1'b1;
    #half scl = 1'b0;
  endtask

  task automatic stop_cond();
    #(half / 2) sda_low = 1'b1;
    #(half / 2) scl = 1'b1;
    #half sda_low = 1'b0;
    #half;
  endtask

  // byte out, msb first, then the acknowledge slot
  task automatic put_byte(input logic [7:0] v, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, nack);
  endtask

  // write frame: address, command and an optional data byte
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic has_data, input logic [7:0] d,
                    output logic ok);
    logic n0;
    logic n1;
    logic n2;
    n2 = 1'b0;
    start_cond();
    put_byte({a, 1'b0}, n0);
    put_byte(cmd, n1);
    if (has_data)
    begin
      put_byte(d, n2);
    end
    stop_cond();
    ok = ~(n0 | n1 | n2);
  endtask

  // read frame: one byte, then not-acknowledge ends it
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    logic n0;
    logic r;
    start_cond();
    put_byte({a, 1'b1}, n0);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
    stop_cond();
    ok = ~n0;
  endtask
endmodule
`default_nettype wire

/* File: tb_i2c_gpio_expander_8bit.sv */
`default_nettype none
module tb_i2c_gpio_expander_8bit;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // signals
  // ************************************************************
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [7:0] ext_pins, gpio_pin_i, gpio_pin_o, gpio_pin_oe, sbyte;
  logic [2:0] straps;
  logic sda_o, sda_oe, sda_line, scl, sda_low, int_n_o, int_n_oe, irq, ok;
  int fails = 0;
  int n_tests = 0;
  int per [4] = '{80, 1000, 2500, 10000};
  logic [4:0] ofs [6] = '{iogx_pkg::IOGX_OFS_CONFIG, iogx_pkg::IOGX_OFS_POLARITY, iogx_pkg::IOGX_OFS_OUTPUT,
                          iogx_pkg::IOGX_OFS_STATUS, iogx_pkg::IOGX_OFS_MASK, iogx_pkg::IOGX_OFS_ADDRESS};
  logic [31:0] rst_val [6] = '{32'hff, 32'h00, 32'hff, 32'h00, 32'h00, 32'h15};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  // output pins show the driven value, inputs the outside level
  assign gpio_pin_i = (gpio_pin_o & gpio_pin_oe) | (ext_pins & ~gpio_pin_oe);
  // pulled-up open-drain data line
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_low;

  iogx_expander u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .gpio_pin_i(gpio_pin_i),
    .gpio_pin_o(gpio_pin_o), .gpio_pin_oe(gpio_pin_oe), .addr_select_pin_i(straps), .int_n_o(int_n_o),
    .int_n_oe(int_n_oe), .irq(irq)
  );

  iogx_i2c_master u_master (.scl(scl), .sda_low(sda_low), .sda(sda_line));

  // 125 MHz core clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ************************************************************
  // report, compare and bus tasks
  // ************************************************************
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // bounded wait for ready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        fails++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask

  // hang guard
  initial
  begin
    #700000;
    fails++;
    give_verdict();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ext_pins = 8'h00;
    straps = 3'h7;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    settle(1);
    // defaults: all pins inputs, nothing driven, interrupt idle
    chk(32'(gpio_pin_oe), 32'h00);
    chk(32'(gpio_pin_o), 32'hff);
    chk(32'(int_n_oe), 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(ofs[i], rdv);
      chk(rdv, rst_val[i]);
    end
    // a strap read low codes its address pair as 00
    straps <= 3'h5;
    settle(8);
    rd_reg(iogx_pkg::IOGX_OFS_ADDRESS, rdv);
    chk(rdv, 32'h11);
    straps <= 3'h7;
    settle(8);
    $display("test reset defaults done");

    // upper nibble outputs, lower nibble inputs
    wr_reg(iogx_pkg::IOGX_OFS_CONFIG, 32'h0f);
    wr_reg(iogx_pkg::IOGX_OFS_OUTPUT, 32'ha5);
    settle(1);
    chk(32'(gpio_pin_oe), 32'hf0);
    chk(32'(gpio_pin_o), 32'ha5);
    rd_reg(iogx_pkg::IOGX_OFS_CONFIG, rdv);
    chk(rdv, 32'h0f);
    rd_reg(iogx_pkg::IOGX_OFS_OUTPUT, rdv);
    chk(rdv, 32'ha5);
    $display("test direction and output done");

    // input change raises the interrupt, a read releases it
    wr_reg(iogx_pkg::IOGX_OFS_MASK, 32'h1);
    wr_reg(iogx_pkg::IOGX_OFS_POLARITY, 32'h03);
    rd_reg(iogx_pkg::IOGX_OFS_POLARITY, rdv);
    chk(rdv, 32'h03);
    ext_pins <= 8'h05;
    settle(8);
    chk(32'(int_n_oe), 32'h1);
    chk(32'(irq), 32'h1);
    rd_reg(iogx_pkg::IOGX_OFS_STATUS, rdv);
    chk(rdv & 32'h1, 32'h1);
    rd_reg(iogx_pkg::IOGX_OFS_INPUT, rdv);
    chk(rdv, 32'ha6);
    settle(8);
    chk(32'(int_n_oe), 32'h0);
    wr_reg(iogx_pkg::IOGX_OFS_STATUS, 32'h1);
    settle(1);
    chk(32'(irq), 32'h0);
    // masked change: pin still flags, irq stays low; return releases
    wr_reg(iogx_pkg::IOGX_OFS_MASK, 32'h0);
    ext_pins <= 8'h04;
    settle(8);
    chk(32'(int_n_oe), 32'h1);
    chk(32'(irq), 32'h0);
    ext_pins <= 8'h05;
    settle(8);
    chk(32'(int_n_oe), 32'h0);
    $display("test interrupt done");

    // serial writes to the output register at each clock rate
    for (int i = 0; i < 4; i++)
    begin
      u_master.set_rate(per[i]);
      u_master.wr(7'h15, 8'h01, 1'b1, 8'h30 + 8'(i), ok);
      chk(32'(ok), 32'h1);
      settle(1);
      chk(32'(gpio_pin_o), 32'h30 + 32'(i));
    end
    u_master.set_rate(80);
    // foreign address: no acknowledge, output untouched
    u_master.wr(7'h14, 8'h01, 1'b1, 8'h77, ok);
    chk(32'(ok), 32'h0);
    settle(1);
    chk(32'(gpio_pin_o), 32'h33);
    // serial read back of config, then of the inverted input
    u_master.wr(7'h15, 8'h03, 1'b0, 8'h00, ok);
    u_master.rd(7'h15, sbyte, ok);
    chk(32'(sbyte), 32'h0f);
    u_master.wr(7'h15, 8'h00, 1'b0, 8'h00, ok);
    u_master.rd(7'h15, sbyte, ok);
    chk(32'(sbyte), 32'h36);
    chk(32'(ok), 32'h1);
    u_master.wr(7'h15, 8'h02, 1'b0, 8'h00, ok);
    u_master.rd(7'h15, sbyte, ok);
    chk(32'(sbyte), 32'h03);
    u_master.wr(7'h15, 8'h01, 1'b0, 8'h00, ok);
    u_master.rd(7'h15, sbyte, ok);
    chk(32'(sbyte), 32'h33);
    // every event kind has left its sticky bit set
    rd_reg(iogx_pkg::IOGX_OFS_STATUS, rdv);
    chk(rdv, 32'h7);
    $display("test serial link done");
    give_verdict();
  end
endmodule
`default_nettype wire
